// [sddma_count.sv]
// Purpose: transfer byte count with per-transfer decrement and reload
// Assumes: load wins over a completed transfer in the same cycle
// Notes: terminal hit is a one-cycle event
`default_nettype none
module sddma_count (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [sddma_pkg::DATA_W-1:0] wdata_i,
  input wire logic done_i,
  input wire logic wide_i,
  input wire logic reload_i,
  output logic [sddma_pkg::COUNT_W-1:0] count_o,
  output logic tc_hit_o
);
  import sddma_pkg::*;

  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] base_reg;
  logic [COUNT_W-1:0] step;
  logic last;

  assign step = wide_i ? STEP_WIDE : STEP_NARROW;
  assign last = (count_reg <= step);
  assign tc_hit_o = done_i && !wr_lo_i && !wr_hi_i && !clear_i && last;
  assign count_o = count_reg;

  // base copy kept for reload
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_reg <= COUNT_RST;
    end else if (ce_i) begin
      if (clear_i) begin
        base_reg <= COUNT_RST;
      end else begin
        if (wr_lo_i) begin
          base_reg[7:0] <= wdata_i;
        end
        if (wr_hi_i) begin
          base_reg[15:8] <= wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= COUNT_RST; // see RULE_02
    end else if (ce_i) begin
      if (clear_i) begin
        count_reg <= COUNT_RST;
      end else if (wr_lo_i || wr_hi_i) begin
        if (wr_lo_i) begin
          count_reg[7:0] <= wdata_i; // see RULE_01
        end
        if (wr_hi_i) begin
          count_reg[15:8] <= wdata_i; // see RULE_01
        end
      end else if (done_i) begin
        if (last) begin
          count_reg <= reload_i ? base_reg : COUNT_RST;
        end else begin
          count_reg <= count_reg - step; // see RULE_03
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sddma_partner.sv]
// Purpose: far side model, card request line and master dma device
// Assumes: changes only off the falling edge of the clock
// Notes: gap_i + 1 idle cycles lie between completed transfers
`default_nettype none
module sddma_partner (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic card_on_i,
  input wire logic [3:0] gap_i,
  input wire logic xfer_req_i,
  output logic card_dma_request_o,
  output logic xfer_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // card request level as the card would drive it
  assign card_dma_request_o = card_on_i;
  // completes transfers only while the slave asks for them
  always @(negedge clock_i) begin
    xfer_done_o <= 1'b0;
    if (!rst_n_i) begin
      wait_n <= 0;
    end else if (xfer_req_i && !xfer_done_o) begin
      if (wait_n >= gap_i) begin
        xfer_done_o <= 1'b1;
        wait_n <= 0;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [sddma_pkg.sv]
// Purpose: shared constants for the socket distributed dma slave channel
// Assumes: byte-wide register port, offsets relative to the dma base
// Notes: none
`default_nettype none
package sddma_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned COUNT_W = 16;

  localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_CMD_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_SW_REQ = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'hb;

  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] STEP_NARROW = 16'h0001;
  localparam logic [COUNT_W-1:0] STEP_WIDE = 16'h0002;

  localparam int unsigned CMD_DISABLE_BIT = 2;
  localparam logic CMD_DISABLE_RST = 1'b0;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;

  localparam logic [5:0] MODE_RST = 6'h00;
  localparam int unsigned MODE_SEL_HI = 7;
  localparam int unsigned MODE_SEL_LO = 6;
  localparam int unsigned MODE_DIR_BIT = 5;
  localparam int unsigned MODE_AUTO_BIT = 4;
  localparam int unsigned MODE_TYPE_HI = 3;
  localparam int unsigned MODE_TYPE_LO = 2;

  localparam logic [1:0] SEL_DEMAND = 2'h0;
  localparam logic [1:0] SEL_SINGLE = 2'h1;
  localparam logic [1:0] SEL_BLOCK = 2'h2;
  localparam logic [1:0] TYPE_NONE = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_READ = 2'h2;

  typedef enum logic {SDDMA_IDLE, SDDMA_ACTIVE} sddma_state_e;
endpackage
`default_nettype wire

// [sddma_slave.sv]
// Purpose: per-socket distributed dma slave channel with its register port
// Assumes: byte register port synchronous to clock_i; mask bit arrives as a level
// Notes: xfer_req_o asks the master dma device to run transfers
// Summary of operation
// RULE_01 - writing count at 04h loads total bytes to move
// RULE_02 - count reads remaining bytes, resets to zero
// RULE_03 - count drops by one (8-bit) or two (16-bit) per transfer
// RULE_04 - command bit 2 zero enables channel, one disables; reset zero
// RULE_05 - other command bits read zero, writes to them ignored
// RULE_06 - offset 08h: command on write, status on read; status resets zero
// RULE_07 - status bits 7..4 read one while card request asserted
// RULE_08 - request status bits ignore the socket request mask
// RULE_09 - terminal count sets status bits 3..0 together
// RULE_10 - terminal count bits clear on status read or channel reset
// RULE_11 - any write to 09h raises a software transfer request
// RULE_12 - software requests are used only in block mode; the channel accepts them in demand, single and block modes
// RULE_13 - mode at 0Bh resets zero, bits 7..2 writable, 1..0 read zero
// RULE_14 - mode bits 7..6: demand, single, block, reserved
// RULE_15 - mode bit 5 address direction, bit 4 reload on terminal
// RULE_16 - mode bits 3..2: none, write to memory, read to card
// RULE_17 - set mask ignores card requests; cleared mask services them; an active demand run still continues on a masked card request
// RULE_18 - a disabled channel starts no servicing
`default_nettype none
module sddma_slave (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [sddma_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [sddma_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [sddma_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic card_dma_request_i,
  input wire logic socket_request_mask_i,
  input wire logic channel_reset_i,
  input wire logic wide_transfer_i,
  input wire logic xfer_done_i,
  output logic xfer_req_o,
  output logic terminal_count_o,
  output logic [1:0] transfer_mode_select_o,
  output logic address_direction_o,
  output logic reload_on_terminal_o,
  output logic [1:0] transfer_direction_o
);
  import sddma_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  sddma_state_e state_reg;
  sddma_state_e state_next;
  logic channel_disable_reg;
  logic [5:0] mode_reg;
  logic [3:0] terminal_count_bits_reg;
  logic sw_req_reg;
  logic [COUNT_W-1:0] count;
  logic tc_hit;
  logic wr_lo, wr_hi, wr_cmd, wr_sw, wr_mode, rd_stat;
  logic [1:0] sel;
  logic [1:0] xtype;
  logic can_start;
  logic [3:0] request_status_bits;

  assign wr_lo = ce_i && reg_wr_i && hit(reg_addr_i, OFS_COUNT_LO);
  assign wr_hi = ce_i && reg_wr_i && hit(reg_addr_i, OFS_COUNT_HI);
  assign wr_cmd = ce_i && reg_wr_i && hit(reg_addr_i, OFS_CMD_STAT); // see RULE_06
  assign wr_sw = ce_i && reg_wr_i && hit(reg_addr_i, OFS_SW_REQ);
  assign wr_mode = ce_i && reg_wr_i && hit(reg_addr_i, OFS_MODE);
  assign rd_stat = ce_i && reg_rd_i && hit(reg_addr_i, OFS_CMD_STAT); // see RULE_06

  assign sel = mode_reg[MODE_SEL_HI-2:MODE_SEL_LO-2];
  assign xtype = mode_reg[MODE_TYPE_HI-2:MODE_TYPE_LO-2];
  assign transfer_mode_select_o = sel; // see RULE_14
  assign address_direction_o = mode_reg[MODE_DIR_BIT-2]; // see RULE_15
  assign reload_on_terminal_o = mode_reg[MODE_AUTO_BIT-2]; // see RULE_15
  assign transfer_direction_o = xtype; // see RULE_16

  sddma_count u_count (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(channel_reset_i),
    .wr_lo_i(wr_lo),
    .wr_hi_i(wr_hi),
    .wdata_i(reg_wdata_i),
    .done_i(xfer_done_i && state_reg == SDDMA_ACTIVE),
    .wide_i(wide_transfer_i),
    .reload_i(mode_reg[MODE_AUTO_BIT-2]),
    .count_o(count),
    .tc_hit_o(tc_hit)
  );

  // command: only the disable bit is stored
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_disable_reg <= CMD_DISABLE_RST; // see RULE_04
    end else if (ce_i) begin
      if (channel_reset_i) begin
        channel_disable_reg <= CMD_DISABLE_RST;
      end else if (wr_cmd) begin
        channel_disable_reg <= reg_wdata_i[CMD_DISABLE_BIT]; // see RULE_04 RULE_05
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_RST; // see RULE_13
    end else if (ce_i) begin
      if (channel_reset_i) begin
        mode_reg <= MODE_RST;
      end else if (wr_mode) begin
        mode_reg <= reg_wdata_i[7:2]; // see RULE_13
      end
    end
  end

  // terminal count flags: a new terminal event beats a read clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      terminal_count_bits_reg <= STATUS_RST[3:0];
    end else if (ce_i) begin
      if (channel_reset_i) begin
        terminal_count_bits_reg <= 4'h0; // see RULE_10
      end else if (tc_hit) begin
        terminal_count_bits_reg <= 4'hf; // see RULE_09
      end else if (rd_stat) begin
        terminal_count_bits_reg <= 4'h0; // see RULE_10
      end
    end
  end

  // software request holds until terminal count or channel reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_req_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_sw) begin
        sw_req_reg <= 1'b1; // see RULE_11
      end else if (channel_reset_i || tc_hit) begin
        sw_req_reg <= 1'b0;
      end
    end
  end

  assign request_status_bits = {4{card_dma_request_i}}; // see RULE_07 RULE_08

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      case (reg_addr_i)
        OFS_COUNT_LO: reg_rdata_o <= count[7:0]; // see RULE_02
        OFS_COUNT_HI: reg_rdata_o <= count[15:8]; // see RULE_02
        OFS_CMD_STAT: reg_rdata_o <= {request_status_bits, terminal_count_bits_reg};
        OFS_MODE: reg_rdata_o <= {mode_reg, 2'b00}; // see RULE_13
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // software requests are trusted to come only in block mode
  assign can_start = !channel_disable_reg // see RULE_18 RULE_04
    && (xtype == TYPE_WRITE || xtype == TYPE_READ)
    && (sel != 2'h3)
    && ((card_dma_request_i && !socket_request_mask_i) || sw_req_reg); // see RULE_17 RULE_12

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SDDMA_IDLE: begin
        if (can_start) begin
          state_next = SDDMA_ACTIVE;
        end
      end
      SDDMA_ACTIVE: begin
        if (xfer_done_i) begin
          if (tc_hit || sel == SEL_SINGLE) begin
            state_next = SDDMA_IDLE;
          end else if (sel == SEL_DEMAND && !card_dma_request_i && !sw_req_reg) begin
            state_next = SDDMA_IDLE;
          end
        end else if (sel == SEL_DEMAND && !card_dma_request_i && !sw_req_reg) begin
          state_next = SDDMA_IDLE;
        end
      end
      default: state_next = SDDMA_IDLE;
    endcase
    if (channel_reset_i) begin
      state_next = SDDMA_IDLE;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SDDMA_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      terminal_count_o <= 1'b0;
    end else if (ce_i) begin
      terminal_count_o <= tc_hit;
    end
  end

  assign xfer_req_o = (state_reg == SDDMA_ACTIVE);

  property p_count_load;
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_lo && !channel_reset_i |=> count[7:0] == $past(reg_wdata_i);
  endproperty
  a_count_load: assert property (p_count_load) else $error("count low byte lost"); // see RULE_01

  property p_count_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && reg_rd_i && reg_addr_i == OFS_COUNT_HI |=> reg_rdata_o == $past(count[15:8]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read mismatch"); // see RULE_02

  property p_decrement;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && xfer_done_i && xfer_req_o && !tc_hit && !wr_lo && !wr_hi && !channel_reset_i
    |=> count == $past(count) - ($past(wide_transfer_i) ? STEP_WIDE : STEP_NARROW);
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad count step"); // see RULE_03

  property p_disabled_idle;
    @(posedge clock_i) disable iff (!rst_n_i)
    !xfer_req_o && channel_disable_reg |=> !xfer_req_o;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled start"); // see RULE_18

  property p_req_status;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_stat |=> reg_rdata_o[7:4] == {4{$past(card_dma_request_i)}};
  endproperty
  a_req_status: assert property (p_req_status) else $error("request status wrong"); // see RULE_07

  property p_tc_set;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && tc_hit && !channel_reset_i |=> terminal_count_bits_reg == 4'hf && terminal_count_o;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("terminal bits not set"); // see RULE_09

  property p_tc_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_stat && !tc_hit ##1 1'b1 |-> terminal_count_bits_reg == 4'h0;
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("terminal bits not cleared"); // see RULE_10

  property p_sw_req;
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_sw |=> sw_req_reg;
  endproperty
  a_sw_req: assert property (p_sw_req) else $error("software request lost"); // see RULE_11

  property p_mode_low;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && reg_rd_i && reg_addr_i == OFS_MODE |=> reg_rdata_o[1:0] == 2'b00;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("mode low bits nonzero"); // see RULE_13

  property p_masked;
    @(posedge clock_i) disable iff (!rst_n_i)
    !xfer_req_o && socket_request_mask_i && !sw_req_reg |=> !xfer_req_o;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request serviced"); // see RULE_17

  property p_single;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i && xfer_req_o && xfer_done_i && sel == SEL_SINGLE |=> !xfer_req_o;
  endproperty
  a_single: assert property (p_single) else $error("single mode kept servicing"); // see RULE_14

  c_start: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(xfer_req_o));
  c_terminal: cover property (@(posedge clock_i) disable iff (!rst_n_i) tc_hit);
  c_block_sw: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    sw_req_reg && sel == SEL_BLOCK && xfer_req_o);
endmodule
`default_nettype wire

// [sddma_slave_bench.sv]
// Purpose: self-checking bench for the distributed dma slave channel
// Assumes: inputs change at the falling edge
// Notes: count model kept as an integer beside the design
`default_nettype none
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end
module sddma_slave_bench;
  import sddma_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, channel_reset_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, v;
  logic card_dma_request_i, socket_request_mask_i, wide_transfer_i, xfer_done_i;
  logic xfer_req_o, terminal_count_o, address_direction_o, reload_on_terminal_o;
  logic [1:0] transfer_mode_select_o, transfer_direction_o;
  logic card_on;
  logic [3:0] gap;
  logic [15:0] n;
  logic [5:0] mo;
  logic m_auto;
  int n_fail, compares, m_cnt, seed, stp, m_base;
  logic [3:0] ofs[6] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hb, 4'h3};
  sddma_slave i_dut (.clock_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .card_dma_request_i, .socket_request_mask_i,
    .channel_reset_i, .wide_transfer_i, .xfer_done_i, .xfer_req_o, .terminal_count_o,
    .transfer_mode_select_o, .address_direction_o, .reload_on_terminal_o,
    .transfer_direction_o);
  sddma_partner i_partner (.clock_i, .rst_n_i, .card_on_i(card_on), .gap_i(gap),
    .xfer_req_i(xfer_req_o), .card_dma_request_o(card_dma_request_i),
    .xfer_done_o(xfer_done_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // reference count, stepped on each accepted transfer
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      m_cnt = 0;
    end else if (xfer_req_o && xfer_done_i) begin
      stp = wide_transfer_i ? 2 : 1;
      m_cnt = (m_cnt <= stp) ? (m_auto ? m_base : 0) : m_cnt - stp;
    end
  end
  task automatic close_out();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rdata_o, e)
  endtask
  task automatic wait_for(input logic want_tc, input logic val, input int lim);
    int i;
    for (i = 0; i < lim && (want_tc ? terminal_count_o : xfer_req_o) !== val; i++) begin
      @(negedge clock_i);
    end
    if (i == lim) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic load_count(input logic [15:0] c);
    wr(OFS_COUNT_LO, c[7:0]);
    wr(OFS_COUNT_HI, c[15:8]);
    m_cnt = c;
    m_base = c;
  endtask
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, channel_reset_i, card_on, wide_transfer_i, m_auto} = '0;
    {reg_addr_i, reg_wdata_i, gap, m_cnt, n_fail, compares} = '0;
    ce_i = 1'b1;
    socket_request_mask_i = 1'b1;
    seed = 51684;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
    // frozen clock enable must drop the write
    ce_i = 1'b0;
    wr(OFS_MODE, 8'hfc);
    ce_i = 1'b1;
    rd_chk(OFS_MODE, 8'h00);
    wr(OFS_CMD_STAT, 8'h04);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[0], ~i[0], i[1:0], 2'b11};
      wr(OFS_MODE, v);
      rd_chk(OFS_MODE, {v[7:2], 2'b00});
      mo = {transfer_mode_select_o, address_direction_o, reload_on_terminal_o,
        transfer_direction_o};
      `CHK(mo, v[7:2])
    end
    wr(OFS_MODE, 8'h04);
    n = 16'h0100 | 16'($random(seed));
    load_count(n);
    rd_chk(OFS_COUNT_LO, n[7:0]);
    rd_chk(OFS_COUNT_HI, n[15:8]);
    socket_request_mask_i = 1'b0;
    card_on = 1'b1;
    gap = 4'($random(seed)) & 4'h3;
    rd_chk(OFS_CMD_STAT, 8'hf0);
    `CHK(xfer_req_o, 1'b0)
    wr(OFS_CMD_STAT, 8'hfb);
    wait_for(1'b0, 1'b1, 3);
    repeat (20) @(negedge clock_i);
    // single mode drops after one transfer even with the card still asking
    wr(OFS_MODE, 8'h44);
    wait_for(1'b0, 1'b0, 8);
    card_on = 1'b0;
    wait_for(1'b0, 1'b0, 8);
    rd_chk(OFS_CMD_STAT, 8'h00);
    rd_chk(OFS_COUNT_LO, 8'(m_cnt));
    rd_chk(OFS_COUNT_HI, 8'(m_cnt >> 8));
    socket_request_mask_i = 1'b1;
    card_on = 1'b1;
    rd_chk(OFS_CMD_STAT, 8'hf0);
    `CHK(xfer_req_o, 1'b0)
    card_on = 1'b0;
    for (int r = 0; r < 4; r++) begin
      wide_transfer_i = r[0];
      gap = 4'($random(seed)) & 4'h3;
      m_auto = (r == 2);
      wr(OFS_MODE, m_auto ? 8'h98 : 8'h88);
      load_count(16'h0001 + (16'($random(seed)) & 16'h001f));
      wr(OFS_SW_REQ, 8'($random(seed)));
      wait_for(1'b1, 1'b1, 400);
      `CHK(m_cnt, m_auto ? m_base : 0)
      `CHK(xfer_req_o, 1'b0)
      rd_chk(OFS_COUNT_LO, 8'(m_cnt));
      if (r == 3) begin
        @(negedge clock_i);
        channel_reset_i = 1'b1;
        @(negedge clock_i);
        channel_reset_i = 1'b0;
      end
      rd_chk(OFS_CMD_STAT, (r == 3) ? 8'h00 : 8'h0f);
      rd_chk(OFS_CMD_STAT, 8'h00);
    end
    // reset after a count load must bring the count back to zero
    load_count(16'h1234);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    rd_chk(OFS_COUNT_HI, 8'(m_cnt >> 8));
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire
